// ==== logic/osgb_serializer.sv ====
// Purpose: output gearbox, parallel core words to serial lane outputs
// Assumes: one clock stands for the fast edge clock; one bit per cycle
// Notes:   a FIFO absorbs words; two pipeline stages feed the shifter
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// (R1) each cell group holds one serializer turning up to eight bits serial
// (R2) seven-to-one mode shifts out the seven low bits of each word
// (R3) eight-to-one mode shifts out all eight bits of each word
// (R4) split mode: two four-bit lanes, low nibble first, high nibble second
// (R5) stage one captures the parallel word from the core side
// (R6) stage two moves the captured word into the fast-side register
// (R7) stage three selects word bits one after another onto the output
// (R8) reset clears all stages and shift state; outputs hold low
module osgb_serializer
	import osgb_pkg::*;
#(
	parameter int WORD_W     = OSGB_WORD_W,
	parameter int FIFO_DEPTH = OSGB_FIFO_DEPTH
) (
	// clock, reset and freeze
	input  wire logic              clk,
	input  wire logic              reset_n,
	input  wire logic              clk_en,
	// gearbox arrangement, sampled with each word entering stage three
	input  wire osgb_mode_t        mode,
	// parallel words from core logic
	input  wire logic              word_valid,
	input  wire logic [WORD_W-1:0] word_data,
	output logic                   word_ready,
	// serial lane outputs and activity
	output logic                   first_lane_q,
	output logic                   second_lane_q,
	output logic                   busy_q
);

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		osgb_word_t            s1;     // stage one, captured word
		osgb_word_t            s2;     // stage two, fast-side word
		logic [WORD_W-1:0]     sh;     // stage three, word being sent
		logic [OSGB_IDX_W-1:0] idx;    // bit now on the output
		logic [OSGB_IDX_W-1:0] last;   // final bit index of this word
		osgb_mode_t            mode;   // arrangement of this word
		logic                  act;    // a word is on the output
		logic                  out_a;  // first lane pin
		logic                  out_c;  // second lane pin
	} osgb_state_t;

	osgb_state_t           st_q;
	osgb_state_t           st_d;
	logic                  f_valid;
	logic [WORD_W-1:0]     f_data;
	logic                  s1_free;
	logic                  s2_free;
	logic                  can_load;
	logic                  load;
	logic [OSGB_IDX_W-1:0] last_sel;
	logic [OSGB_IDX_W-1:0] nidx;

	// ************************************************************
	// input buffer
	// ************************************************************
	// back-pressure reaches the core through word_ready
	osgb_fifo #(
		.W     (WORD_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk     (clk),
		.reset_n (reset_n),
		.clk_en  (clk_en),
		.s_valid (word_valid),
		.s_data  (word_data),
		.s_ready (word_ready),
		.m_valid (f_valid),
		.m_data  (f_data),
		.m_ready (s1_free)
	);

	// ************************************************************
	// pipeline handshakes
	// ************************************************************
	// stage three takes a word when idle or on its final bit,
	// so back-to-back words leave no gap on the line
	always_comb begin
		can_load = !st_q.act || (st_q.idx == st_q.last);
		load     = can_load && st_q.s2.vld;
		s2_free  = !st_q.s2.vld || can_load;
		s1_free  = !st_q.s1.vld || s2_free;
		case (mode)
			OSGB_MODE_SER7:  last_sel = OSGB_LAST_SER7;  // R2
			OSGB_MODE_DDR8:  last_sel = OSGB_LAST_DDR8;  // R3
			OSGB_MODE_SPLIT: last_sel = OSGB_LAST_SPLIT; // R4
			default:         last_sel = OSGB_LAST_DDR8;
		endcase
	end

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		st_d = st_q;
		nidx = OSGB_IDX_W'(st_q.idx + 1'b1);
		// stage one: capture from the buffer when it can move on
		if (s1_free) begin
			st_d.s1.vld  = f_valid;         // R5
			st_d.s1.data = f_data;          // R5
		end
		// stage two: hand the word to the fast-side register
		if (s2_free) begin
			st_d.s2 = st_q.s1;              // R6
		end
		// stage three: shift and select onto the lane outputs
		if (load) begin
			st_d.sh    = st_q.s2.data;
			st_d.idx   = OSGB_IDX_FIRST;
			st_d.last  = last_sel;
			st_d.mode  = mode;
			st_d.act   = 1'b1;
			st_d.out_a = st_q.s2.data[OSGB_IDX_FIRST];  // R7
			st_d.out_c = (mode == OSGB_MODE_SPLIT)
				? st_q.s2.data[OSGB_SPLIT_OFS]          // R4
				: OSGB_IDLE_LVL;
		end else if (st_q.act && (st_q.idx != st_q.last)) begin
			st_d.idx   = nidx;
			st_d.out_a = st_q.sh[nidx];                 // R7
			st_d.out_c = (st_q.mode == OSGB_MODE_SPLIT)
				? st_q.sh[OSGB_IDX_W'(nidx + OSGB_SPLIT_OFS)] // R4
				: OSGB_IDLE_LVL;                        // R1
		end else if (st_q.act) begin
			// nothing queued: line returns to its idle level
			st_d.act   = 1'b0;
			st_d.out_a = OSGB_IDLE_LVL;
			st_d.out_c = OSGB_IDLE_LVL;
		end
	end

	// ************************************************************
	// state register
	// ************************************************************
	// a frozen clock enable holds the line at its current bit
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= '0;                     // R8
		end else if (clk_en) begin
			st_q <= st_d;
		end
	end

	// outputs straight from the state register
	assign first_lane_q  = st_q.out_a;
	assign second_lane_q = st_q.out_c;
	assign busy_q        = st_q.act;

	// ************************************************************
	// checks
	// ************************************************************
	// stage one takes what the buffer offered
	s1_capture_a: assert property ( // R5
		@(posedge clk) disable iff (!reset_n || !clk_en)
		(f_valid && s1_free) |=> (st_q.s1.vld
			&& st_q.s1.data == $past(f_data)))
		else $error("stage one missed a buffered word");

	// stage two takes the stage-one word
	s2_transfer_a: assert property ( // R6
		@(posedge clk) disable iff (!reset_n || !clk_en)
		(st_q.s1.vld && s2_free) |=> (st_q.s2.vld
			&& st_q.s2.data == $past(st_q.s1.data)))
		else $error("stage two missed a word");

	// first bit appears the cycle after a load
	shift_first_a: assert property ( // R7
		@(posedge clk) disable iff (!reset_n || !clk_en)
		load |=> (st_q.act && st_q.idx == OSGB_IDX_FIRST
			&& st_q.out_a == $past(st_q.s2.data[0])))
		else $error("first serial bit wrong after load");

	// seven-to-one: bit six is the seventh bit out
	ser7_order_a: assert property ( // R2
		@(posedge clk) disable iff (!reset_n || !clk_en)
		(load && mode == OSGB_MODE_SER7) |-> ##7
			(st_q.idx == OSGB_LAST_SER7
			&& st_q.out_a == $past(st_q.s2.data[6], 7)))
		else $error("seven-to-one word not shifted in order");

	// eight-to-one: bit seven is the eighth bit out
	ddr8_order_a: assert property ( // R3
		@(posedge clk) disable iff (!reset_n || !clk_en)
		(load && mode == OSGB_MODE_DDR8) |-> ##8
			(st_q.idx == OSGB_LAST_DDR8
			&& st_q.out_a == $past(st_q.s2.data[7], 8)))
		else $error("eight-to-one word not shifted in order");

	// split: both lanes end on their top nibble bit together
	split_lanes_a: assert property ( // R4
		@(posedge clk) disable iff (!reset_n || !clk_en)
		(load && mode == OSGB_MODE_SPLIT) |-> ##4
			(st_q.idx == OSGB_LAST_SPLIT
			&& st_q.out_a == $past(st_q.s2.data[3], 4)
			&& st_q.out_c == $past(st_q.s2.data[7], 4)))
		else $error("split lanes carry wrong bits");

	// single serializer uses only the first lane
	one_lane_a: assert property ( // R1
		@(posedge clk) disable iff (!reset_n)
		(st_q.mode != OSGB_MODE_SPLIT) |-> (st_q.out_c == OSGB_IDLE_LVL))
		else $error("second lane driven outside split mode");

	// after reset release everything starts empty and low
	reset_clear_a: assert property ( // R8
		@(posedge clk)
		$rose(reset_n) |-> (!st_q.act && !st_q.s1.vld && !st_q.s2.vld
			&& st_q.out_a == OSGB_IDLE_LVL && st_q.out_c == OSGB_IDLE_LVL))
		else $error("pipeline not cleared by reset");

	// idle line rests at the idle level
	idle_low_a: assert property ( // R8
		@(posedge clk) disable iff (!reset_n)
		!st_q.act |-> (st_q.out_a == OSGB_IDLE_LVL
			&& st_q.out_c == OSGB_IDLE_LVL))
		else $error("idle line not at idle level");

	// ************************************************************
	// back-pressure and ordering checks
	// ************************************************************
	// a word waiting in the buffer stays put until stage one is free
	buffer_hold_a: assert property ( // R5
		@(posedge clk) disable iff (!reset_n || !clk_en)
		(f_valid && !s1_free) |=> (f_valid
			&& $stable(f_data)))
		else $error("buffered word changed while blocked");

	// stage one keeps its word while stage two holds a word the shifter cannot take yet
	s1_hold_a: assert property ( // R5
		@(posedge clk) disable iff (!reset_n || !clk_en)
		(st_q.s1.vld && !s1_free) |=> (st_q.s1.vld
			&& $stable(st_q.s1.data)))
		else $error("stage one overwritten while blocked");

	// stage two keeps its word until the shifter can take it
	s2_hold_a: assert property ( // R6
		@(posedge clk) disable iff (!reset_n || !clk_en)
		(st_q.s2.vld && !s2_free) |=> (st_q.s2.vld
			&& $stable(st_q.s2.data)))
		else $error("stage two overwritten while blocked");

	// inside a word the bit index climbs by exactly one per cycle
	idx_step_a: assert property ( // R7
		@(posedge clk) disable iff (!reset_n || !clk_en)
		(st_q.act && st_q.idx != st_q.last) |=> (st_q.act
			&& st_q.idx == OSGB_IDX_W'($past(st_q.idx) + 1'b1)))
		else $error("bit index skipped or stalled");

	// a queued word follows the last bit with no idle gap
	no_gap_a: assert property ( // R7
		@(posedge clk) disable iff (!reset_n || !clk_en)
		(st_q.act && st_q.idx == st_q.last && st_q.s2.vld)
			|=> (st_q.act && st_q.idx == OSGB_IDX_FIRST))
		else $error("gap between back-to-back words");

	// with nothing queued the line rests right after the last bit
	line_rest_a: assert property ( // R7
		@(posedge clk) disable iff (!reset_n || !clk_en)
		(st_q.act && st_q.idx == st_q.last && !st_q.s2.vld)
			|=> (!st_q.act && st_q.out_a == OSGB_IDLE_LVL
			&& st_q.out_c == OSGB_IDLE_LVL))
		else $error("line not released after last bit");

	// the arrangement of a word is kept until the next load
	mode_hold_a: assert property ( // R2
		@(posedge clk) disable iff (!reset_n || !clk_en)
		(st_q.act && !load) |=> (st_q.mode
			== $past(st_q.mode)))
		else $error("arrangement changed inside a word");

	// split mode: the second lane opens on the high nibble base bit
	split_first_a: assert property ( // R4
		@(posedge clk) disable iff (!reset_n || !clk_en)
		(load && mode == OSGB_MODE_SPLIT) |=> (st_q.out_c
			== $past(st_q.s2.data[OSGB_SPLIT_OFS])))
		else $error("second lane opened on wrong bit");

	// seven-to-one never reaches the top bit of the word
	ser7_short_a: assert property ( // R2
		@(posedge clk) disable iff (!reset_n)
		(st_q.act && st_q.mode == OSGB_MODE_SER7)
			|-> (st_q.idx <= OSGB_LAST_SER7))
		else $error("seven-to-one sent an eighth bit");

	// split lanes never pass their fourth bit
	split_short_a: assert property ( // R4
		@(posedge clk) disable iff (!reset_n)
		(st_q.act && st_q.mode == OSGB_MODE_SPLIT)
			|-> (st_q.idx <= OSGB_LAST_SPLIT))
		else $error("split lane ran past four bits");

	// the spare code falls back to the eight-bit single gearbox
	wide_len_a: assert property ( // R3
		@(posedge clk) disable iff (!reset_n || !clk_en)
		(load && mode != OSGB_MODE_SER7 && mode != OSGB_MODE_SPLIT)
			|=> (st_q.last == OSGB_LAST_DDR8))
		else $error("eight-bit word given wrong length");

	// a low clock enable holds lane outputs and activity still
	freeze_hold_a: assert property ( // R7
		@(posedge clk) disable iff (!reset_n)
		!clk_en |=> ($stable(st_q.out_a) && $stable(st_q.out_c)
			&& $stable(st_q.act)))
		else $error("line moved while clock enable low");

endmodule // osgb_serializer
`default_nettype wire

// ==== include/osgb_pkg.sv ====
// Purpose: shared types and constants of the output gearbox serializer
// Assumes: one clock; parallel words arrive from core logic on that clock
// Notes:   no registers reachable by software; mode is a plain input
package osgb_pkg;

	// ************************************************************
	// widths and depths
	// ************************************************************
	localparam int OSGB_WORD_W     = 8;  // parallel word from the core
	localparam int OSGB_FIFO_DEPTH = 8;  // words buffered ahead of stage one
	localparam int OSGB_IDX_W      = 3;  // bit index inside one word

	// ************************************************************
	// per-mode bit positions
	// ************************************************************
	localparam logic [2:0] OSGB_LAST_SER7  = 3'h6; // seven bits, 0..6
	localparam logic [2:0] OSGB_LAST_DDR8  = 3'h7; // eight bits, 0..7
	localparam logic [2:0] OSGB_LAST_SPLIT = 3'h3; // four bits per lane
	localparam logic [2:0] OSGB_SPLIT_OFS  = 3'h4; // second lane base bit
	localparam logic [2:0] OSGB_IDX_FIRST  = 3'h0; // first bit shifted out
	localparam logic       OSGB_IDLE_LVL   = 1'b0; // serial level when idle

	// ************************************************************
	// types
	// ************************************************************
	// gearbox arrangement
	typedef enum logic [1:0] {
		OSGB_MODE_SER7  = 2'b00, // one seven-to-one serializer
		OSGB_MODE_DDR8  = 2'b01, // one eight-to-one gearbox
		OSGB_MODE_SPLIT = 2'b10  // two four-to-one gearboxes
	} osgb_mode_t;

	// one parallel word with its valid mark
	typedef struct packed {
		logic                   vld;
		logic [OSGB_WORD_W-1:0] data;
	} osgb_word_t;

endpackage

// ==== logic/osgb_fifo.sv ====
// Purpose: small synchronous word FIFO with valid and ready on both sides
// Assumes: both sides run on clk; clk_en low freezes everything
// Notes:   s_ready and m_valid come from flip-flops
`timescale 1ns/10ps
`default_nettype none
module osgb_fifo
	import osgb_pkg::*;
#(
	parameter int W     = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         reset_n,
	input  wire logic         clk_en,
	// filling side
	input  wire logic         s_valid,
	input  wire logic [W-1:0] s_data,
	output logic              s_ready,
	// draining side
	output logic              m_valid,
	output logic [W-1:0]      m_data,
	input  wire logic         m_ready
);
	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW-1:0]           wr;
		logic [PW-1:0]           rd;
		logic [PW:0]             cnt;
		logic                    rdy;
		logic                    vld;
	} osgb_fifo_state_t;

	osgb_fifo_state_t st_q;
	osgb_fifo_state_t st_d;
	logic             push;
	logic             pop;

	// ************************************************************
	// next state
	// ************************************************************
	// flags are precomputed so both handshakes leave flip-flops
	always_comb begin
		st_d = st_q;
		push = s_valid && st_q.rdy;
		pop  = m_ready && st_q.vld;
		if (push) begin
			st_d.mem[st_q.wr] = s_data;
			st_d.wr           = PW'(st_q.wr + 1'b1);
		end
		if (pop) begin
			st_d.rd = PW'(st_q.rd + 1'b1);
		end
		st_d.cnt = (PW+1)'(st_q.cnt + {{PW{1'b0}}, push}
			- {{PW{1'b0}}, pop});
		st_d.rdy = (st_d.cnt != (PW+1)'(DEPTH));
		st_d.vld = (st_d.cnt != '0);
	end

	// state register, frozen while clk_en is low
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q     <= '0;
			st_q.rdy <= 1'b1;
		end else if (clk_en) begin
			st_q <= st_d;
		end
	end

	assign s_ready = st_q.rdy;
	assign m_valid = st_q.vld;
	assign m_data  = st_q.mem[st_q.rd];

endmodule // osgb_fifo
`default_nettype wire

// ==== bench/osgb_core_model.sv ====
// Purpose: core-side word source feeding the serializer word port
// Assumes: a word is taken at an edge where valid and ready are both high
// Notes:   idle data inverts every cycle, alternating with the last word
`timescale 1ns/10ps
`default_nettype none
module osgb_core_model
	import osgb_pkg::*;
(
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   reset_n,
	// batch control from the bench
	input  wire logic                   go,
	input  wire logic [4:0]             n_words,
	output logic [4:0]                  taken,
	// word port of the serializer
	input  wire logic                   word_ready,
	output logic                        word_valid,
	output logic [OSGB_WORD_W-1:0]      word_data
);
	// ************************************************************
	// handshake sampling
	// ************************************************************
	logic took_n;
	logic go_n;
	// falling edge sampling keeps clear of flop updates and bench drives
	always @(negedge clk) begin
		took_n = word_valid & word_ready;
		go_n = go;
	end
	// ************************************************************
	// word offering
	// ************************************************************
	initial begin
		taken = 5'h00;
		word_valid = 1'b0;
		word_data = 8'h00;
	end
	// each word held unchanged until taken, then the next follows
	always @(posedge clk or negedge reset_n) begin
		#2;
		if (!reset_n || !go_n) begin
			taken = 5'h00;
		end else if (took_n) begin
			taken = taken + 5'h01;
		end
		word_valid = reset_n && go_n && (taken < n_words);
		if (word_valid) begin
			word_data = 8'hA5 ^ {taken, 3'h0} ^ {3'h0, taken};
		end else begin
			word_data = ~word_data;
		end
	end
endmodule // osgb_core_model
`default_nettype wire

// ==== bench/output_gearbox_serializer_bench.sv ====
// Purpose: self-checking bench of the output gearbox serializer
// Assumes: bits leave LSB first, back to back, first bit 3 edges after take
// Notes:   outputs sampled 1 ns after the edge, inputs driven at 2 ns
`timescale 1ns/10ps
`default_nettype none
module output_gearbox_serializer_bench
	import osgb_pkg::*;
;
	// ************************************************************
	// signals
	// ************************************************************
	logic       clk, reset_n, clk_en, go, word_valid, word_ready;
	logic       first_lane_q, second_lane_q, busy_q, saw_full;
	logic [4:0] n_words, taken;
	logic [7:0] word_data;
	osgb_mode_t mode;
	int         bad_count, n_compared, cyc;
	// ************************************************************
	// instances
	// ************************************************************
	osgb_serializer osgb_serializer_i (.clk(clk), .reset_n(reset_n),
		.clk_en(clk_en), .mode(mode), .word_valid(word_valid),
		.word_data(word_data), .word_ready(word_ready),
		.first_lane_q(first_lane_q), .second_lane_q(second_lane_q),
		.busy_q(busy_q));
	osgb_core_model osgb_core_model_i (.clk(clk), .reset_n(reset_n),
		.go(go), .n_words(n_words), .taken(taken),
		.word_ready(word_ready), .word_valid(word_valid),
		.word_data(word_data));
	// clock, and a ceiling on run length against hangs
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			bad_count++;
			wrap_up();
		end
	end
	// refusal seen while a word waits
	always @(negedge clk) if (word_valid && !word_ready) saw_full = 1'b1;
	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic check(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic idle_check();
		check("lane a idle", {7'h00, first_lane_q}, {7'h00, OSGB_IDLE_LVL});
		check("lane c idle", {7'h00, second_lane_q}, 8'h00);
		check("busy idle", {7'h00, busy_q}, 8'h00);
	endtask
	// send n words in one mode and follow every bit on both lanes
	task automatic run_batch(input osgb_mode_t m, input int n);
		int len;
		int edges;
		logic [7:0] d;
		logic c;
		len = (m == OSGB_MODE_SER7) ? 7 : (m == OSGB_MODE_SPLIT) ? 4 : 8;
		@(posedge clk);
		#2 mode = m;
		n_words = n[4:0];
		go = 1'b1;
		edges = 0;
		do begin
			@(posedge clk);
			#1 edges++;
		end while (busy_q !== 1'b1 && edges < 200);
		check("first bit latency", edges[7:0], 8'h05);
		for (int w = 0; w < n; w++) begin
			d = 8'hA5 ^ {w[4:0], 3'h0} ^ {3'h0, w[4:0]};
			for (int i = 0; i < len; i++) begin
				c = (m == OSGB_MODE_SPLIT) ? d[(i + 4) % 8] : 1'b0;
				check("lane a bit", {7'h00, first_lane_q}, {7'h00, d[i]});
				check("lane c bit", {7'h00, second_lane_q}, {7'h00, c});
				check("busy bit", {7'h00, busy_q}, 8'h01);
				@(posedge clk);
				#1;
			end
		end
		idle_check();
		#1 go = 1'b0;
	endtask
	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic test_modes();
		run_batch(OSGB_MODE_SER7, 3);
		run_batch(OSGB_MODE_DDR8, 3);
		run_batch(OSGB_MODE_SPLIT, 3);
		run_batch(osgb_mode_t'(2'h3), 2);
		$display("test modes done");
	endtask
	// a burst longer than the buffer must be refused yet never lose a word
	task automatic test_full();
		saw_full = 1'b0;
		run_batch(OSGB_MODE_DDR8, 16);
		check("refused when full", {7'h00, saw_full}, 8'h01);
		$display("test full done");
	endtask
	// freeze in mid-word, then reset in mid-word, then a clean batch
	task automatic test_freeze_reset();
		logic v;
		int t;
		@(posedge clk);
		#2 mode = OSGB_MODE_DDR8;
		n_words = 5'h01;
		go = 1'b1;
		t = 0;
		do begin
			@(posedge clk);
			#1 t++;
		end while (busy_q !== 1'b1 && t < 50);
		v = first_lane_q;
		#1 clk_en = 1'b0;
		repeat (3) begin
			@(posedge clk);
			#1 check("frozen lane", {7'h00, first_lane_q}, {7'h00, v});
			check("frozen busy", {7'h00, busy_q}, 8'h01);
		end
		#1 reset_n = 1'b0;
		clk_en = 1'b1;
		go = 1'b0;
		#1 idle_check();
		check("ready in reset", {7'h00, word_ready}, 8'h01);
		@(posedge clk);
		#2 reset_n = 1'b1;
		run_batch(OSGB_MODE_SER7, 2);
		$display("test freeze reset done");
	endtask
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		reset_n = 1'b0;
		clk_en = 1'b1;
		mode = OSGB_MODE_SER7;
		go = 1'b0;
		n_words = 5'h00;
		bad_count = 0;
		n_compared = 0;
		cyc = 0;
		saw_full = 1'b0;
		repeat (8) @(posedge clk);
		#1 idle_check();
		#1 reset_n = 1'b1;
		test_modes();
		test_full();
		test_freeze_reset();
		wrap_up();
	end
endmodule // output_gearbox_serializer_bench
`default_nettype wire
